// file: rtl/ssr_top.sv
/*
  ssr_top: receive side of a serial port in synchronous slave mode,
  with its registers on an Avalon-MM slave with waitrequest.
  assumes: the external master drives shift clock and data; the core
  supplies its interrupt enables on core_clk.

*/
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ssr_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // link pins
  input  wire logic        link_clk_pin,
  input  wire logic        link_data_pin,
  // core interrupt enables
  input  wire logic        global_interrupt_enable,
  input  wire logic        peripheral_interrupt_enable,
  // requests to the core
  output logic             rx_irq_req,
  output logic             wake_req,
  output logic             vector_req,
  output logic             irq
);

  ssr_word_if wif ();

  ssr_pkg::ssr_bus_state_type bus_ff;
  ssr_pkg::ssr_bus_state_type nxt_bus;
  logic        wait_ff;
  logic        nxt_wait;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  logic [7:0]  rxs_ctrl_ff;
  logic [7:0]  nxt_rxs_ctrl;
  logic        frame_ff;
  logic        nxt_frame;
  logic        overrun_ff;
  logic        nxt_overrun;
  logic        ninth_ff;
  logic        nxt_ninth;
  logic [7:0]  rxbuf_ff;
  logic [7:0]  nxt_rxbuf;
  logic        flag_ff;
  logic        nxt_flag;
  logic        rie_ff;
  logic        nxt_rie;
  logic [7:0]  txs_ff;
  logic [7:0]  nxt_txs;
  logic [7:0]  baud_ff;
  logic [7:0]  nxt_baud;
  logic [7:0]  baud_hi_ff;
  logic [7:0]  nxt_baud_hi;
  logic [7:0]  baud_lo_ff;
  logic [7:0]  nxt_baud_lo;
  logic        rx_irq_ff;
  logic        nxt_rx_irq;
  logic        wake_ff;
  logic        nxt_wake;
  logic        vector_ff;
  logic        nxt_vector;

  logic        req_seen;
  logic        rd_seen;
  logic        wr_take;
  logic [7:0]  wbyte;
  logic [31:0] rd_value;
  logic        slave_mode;
  logic        word_accept;
  logic        word_overrun;
  logic        frame_set;
  logic [ssr_pkg::EVT_W-1:0] evt_set;
  logic [ssr_pkg::EVT_W-1:0] evt_status;
  logic [ssr_pkg::EVT_W-1:0] evt_mask;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  // reads act when the request is first seen, writes when
  // waitrequest is low; readdata and its side effects stay paired
  assign req_seen = (bus_ff == ssr_pkg::BUS_IDLE) & (avs_read | avs_write);
  assign rd_seen  = req_seen & avs_read;
  assign wr_take  = (bus_ff == ssr_pkg::BUS_ACK) & avs_write & avs_byteenable[0];
  assign wbyte    = avs_writedata[7:0];

  always_comb
  begin
    rd_value = ssr_pkg::DATA32_ZERO;
    unique case (avs_address)
      ssr_pkg::OFS_RX_STATUS:
        rd_value[7:0] = {rxs_ctrl_ff[7:3], frame_ff, overrun_ff, ninth_ff};
      ssr_pkg::OFS_RX_BUFFER:  rd_value[7:0] = rxbuf_ff;
      ssr_pkg::OFS_TX_STATUS:  rd_value[7:0] = txs_ff;
      ssr_pkg::OFS_BAUD_CTRL:
      begin
        rd_value[7:0] = baud_ff;
        rd_value[ssr_pkg::BAUD_IDLE] = ~wif.busy;
      end
      ssr_pkg::OFS_BAUD_HI:    rd_value[7:0] = baud_hi_ff;
      ssr_pkg::OFS_BAUD_LO:    rd_value[7:0] = baud_lo_ff;
      ssr_pkg::OFS_EVT_STATUS: rd_value[ssr_pkg::EVT_W-1:0] = evt_status;
      ssr_pkg::OFS_EVT_MASK:   rd_value[ssr_pkg::EVT_W-1:0] = evt_mask;
      ssr_pkg::OFS_RX_INT:
      begin
        rd_value[ssr_pkg::RXI_ENABLE] = rie_ff;
        rd_value[ssr_pkg::RXI_FLAG]   = flag_ff;
      end
      default:                 rd_value = ssr_pkg::DATA32_ZERO;
    endcase
  end

  always_comb
  begin
    nxt_bus   = bus_ff;
    nxt_wait  = 1'b1;
    nxt_rdata = rdata_ff;
    unique case (bus_ff)
      ssr_pkg::BUS_IDLE:
        if (avs_read | avs_write)
        begin
          nxt_bus   = ssr_pkg::BUS_ACK;
          nxt_wait  = 1'b0;
          nxt_rdata = avs_read ? rd_value : ssr_pkg::DATA32_ZERO;
        end
      ssr_pkg::BUS_ACK:
        nxt_bus = ssr_pkg::BUS_IDLE;
      default:
        nxt_bus = ssr_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_ff   <= ssr_pkg::BUS_IDLE;
      wait_ff  <= 1'b1;
      rdata_ff <= ssr_pkg::DATA32_ZERO;
    end
    else
    begin
      bus_ff   <= nxt_bus;
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;

  // ------------------------------------------------------------
  // receive control and registers
  // ------------------------------------------------------------
  // single-receive bit is stored only, it never gates shifting
  assign slave_mode = rxs_ctrl_ff[ssr_pkg::RXS_PORT_EN] & txs_ff[ssr_pkg::TXS_SYNC]
                      & ~txs_ff[ssr_pkg::TXS_CLK_SRC];
  // no low-power input: sleep or idle never stops reception
  assign wif.shift_enable  = slave_mode & rxs_ctrl_ff[ssr_pkg::RXS_CONT_EN] & ~overrun_ff;
  assign wif.nine_bit      = rxs_ctrl_ff[ssr_pkg::RXS_NINE_EN];
  assign wif.sample_rising = baud_ff[ssr_pkg::BAUD_POL];

  // an unread buffer makes the new word an overrun, it is dropped
  assign word_accept  = wif.word_done & ~flag_ff;
  assign word_overrun = wif.word_done & flag_ff;
  // sync words have no stop bit: a word cut off by leaving slave
  // mode is what counts as a framing fault here
  assign frame_set    = wif.busy & ~slave_mode & rxs_ctrl_ff[ssr_pkg::RXS_CONT_EN];

  always_comb
  begin
    nxt_rxs_ctrl = rxs_ctrl_ff;
    nxt_txs      = txs_ff;
    nxt_baud     = baud_ff;
    nxt_baud_hi  = baud_hi_ff;
    nxt_baud_lo  = baud_lo_ff;
    nxt_rie      = rie_ff;
    nxt_rxbuf    = rxbuf_ff;
    nxt_ninth    = ninth_ff;
    nxt_flag     = flag_ff;
    nxt_overrun  = overrun_ff | word_overrun;
    nxt_frame    = frame_ff | frame_set;
    if (wr_take)
    begin
      unique case (avs_address)
        ssr_pkg::OFS_RX_STATUS:  nxt_rxs_ctrl = wbyte & ssr_pkg::RXS_WR_MASK;
        ssr_pkg::OFS_TX_STATUS:  nxt_txs      = wbyte;
        ssr_pkg::OFS_BAUD_CTRL:  nxt_baud     = wbyte & ssr_pkg::BAUD_WR_MASK;
        ssr_pkg::OFS_BAUD_HI:    nxt_baud_hi  = wbyte;
        ssr_pkg::OFS_BAUD_LO:    nxt_baud_lo  = wbyte;
        ssr_pkg::OFS_RX_INT:     nxt_rie      = wbyte[ssr_pkg::RXI_ENABLE];
        default:                 nxt_rie      = rie_ff;
      endcase
    end
    if (!rxs_ctrl_ff[ssr_pkg::RXS_CONT_EN])
    begin
      nxt_overrun = 1'b0;
      nxt_frame   = 1'b0;
    end
    if (rd_seen && (avs_address == ssr_pkg::OFS_RX_BUFFER))
      nxt_flag = 1'b0;
    if (word_accept)
    begin
      nxt_rxbuf = wif.word[7:0];
      nxt_ninth = wif.word[8];
      nxt_flag  = 1'b1;
    end
    nxt_rx_irq = nxt_flag & nxt_rie;
    nxt_wake   = nxt_rx_irq;
    nxt_vector = nxt_rx_irq & global_interrupt_enable & peripheral_interrupt_enable;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxs_ctrl_ff <= ssr_pkg::REG8_RST;
      txs_ff      <= ssr_pkg::REG8_RST;
      baud_ff     <= ssr_pkg::REG8_RST;
      baud_hi_ff  <= ssr_pkg::REG8_RST;
      baud_lo_ff  <= ssr_pkg::REG8_RST;
      rxbuf_ff    <= ssr_pkg::REG8_RST;
      rie_ff      <= 1'b0;
      ninth_ff    <= 1'b0;
      flag_ff     <= 1'b0;
      overrun_ff  <= 1'b0;
      frame_ff    <= 1'b0;
      rx_irq_ff   <= 1'b0;
      wake_ff     <= 1'b0;
      vector_ff   <= 1'b0;
    end
    else
    begin
      rxs_ctrl_ff <= nxt_rxs_ctrl;
      txs_ff      <= nxt_txs;
      baud_ff     <= nxt_baud;
      baud_hi_ff  <= nxt_baud_hi;
      baud_lo_ff  <= nxt_baud_lo;
      rxbuf_ff    <= nxt_rxbuf;
      rie_ff      <= nxt_rie;
      ninth_ff    <= nxt_ninth;
      flag_ff     <= nxt_flag;
      overrun_ff  <= nxt_overrun;
      frame_ff    <= nxt_frame;
      rx_irq_ff   <= nxt_rx_irq;
      wake_ff     <= nxt_wake;
      vector_ff   <= nxt_vector;
    end
  end

  assign rx_irq_req = rx_irq_ff;
  assign wake_req   = wake_ff;
  assign vector_req = vector_ff;

  // ------------------------------------------------------------
  // sub-blocks
  // ------------------------------------------------------------
  always_comb
  begin
    evt_set                      = '0;
    evt_set[ssr_pkg::EVT_WORD]    = word_accept;
    evt_set[ssr_pkg::EVT_OVERRUN] = word_overrun & ~overrun_ff;
    evt_set[ssr_pkg::EVT_FRAME]   = frame_set & ~frame_ff;
  end

  ssr_shifter u_shifter (
    .core_clk      (core_clk),
    .arst_n        (arst_n),
    .link_clk_pin  (link_clk_pin),
    .link_data_pin (link_data_pin),
    .wif           (wif.shifter)
  );

  ssr_irq u_irq (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .evt_set    (evt_set),
    .status_rd  (rd_seen & (avs_address == ssr_pkg::OFS_EVT_STATUS)),
    .mask_wr    (wr_take & (avs_address == ssr_pkg::OFS_EVT_MASK)),
    .mask_wdata (wbyte[ssr_pkg::EVT_W-1:0]),
    .status     (evt_status),
    .mask       (evt_mask),
    .irq        (irq)
  );

endmodule : ssr_top
`default_nettype wire

// file: rtl/ssr_pkg.sv
/*
  ssr_pkg: constants shared by the synchronous slave receiver.
  assumes: every user writes ssr_pkg::name, nothing is imported.
*/
package ssr_pkg;

  // --------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------
  localparam logic [5:0] OFS_RX_STATUS  = 6'h00;
  localparam logic [5:0] OFS_RX_BUFFER  = 6'h04;
  localparam logic [5:0] OFS_TX_STATUS  = 6'h08;
  localparam logic [5:0] OFS_BAUD_CTRL  = 6'h0C;
  localparam logic [5:0] OFS_BAUD_HI    = 6'h10;
  localparam logic [5:0] OFS_BAUD_LO    = 6'h14;
  localparam logic [5:0] OFS_EVT_STATUS = 6'h18;
  localparam logic [5:0] OFS_EVT_MASK   = 6'h1C;
  localparam logic [5:0] OFS_RX_INT     = 6'h20;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int unsigned RXS_PORT_EN  = 7;
  localparam int unsigned RXS_NINE_EN  = 6;
  localparam int unsigned RXS_CONT_EN  = 4;
  localparam int unsigned RXS_FRAME    = 2;
  localparam int unsigned RXS_OVERRUN  = 1;
  localparam int unsigned RXS_NINTH    = 0;
  localparam int unsigned TXS_CLK_SRC  = 7;
  localparam int unsigned TXS_SYNC     = 4;
  localparam int unsigned BAUD_IDLE    = 6;
  localparam int unsigned BAUD_POL     = 4;
  localparam int unsigned RXI_ENABLE   = 0;
  localparam int unsigned RXI_FLAG     = 1;
  localparam int unsigned EVT_WORD     = 0;
  localparam int unsigned EVT_OVERRUN  = 1;
  localparam int unsigned EVT_FRAME    = 2;
  localparam int unsigned EVT_W        = 3;

  // --------------------------------------------------------------
  // write masks and reset values
  // --------------------------------------------------------------
  localparam logic [7:0] RXS_WR_MASK   = 8'hF8;
  localparam logic [7:0] BAUD_WR_MASK  = 8'h9B;
  localparam logic [7:0] REG8_RST      = 8'h00;
  localparam logic [31:0] DATA32_ZERO  = 32'h0000_0000;

  // --------------------------------------------------------------
  // word framing
  // --------------------------------------------------------------
  localparam logic [3:0] LAST_BIT_8    = 4'h7;
  localparam logic [3:0] LAST_BIT_9    = 4'h8;
  localparam logic [3:0] COUNT_ZERO    = 4'h0;
  localparam logic [3:0] COUNT_ONE     = 4'h1;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } ssr_bus_state_type;

endpackage : ssr_pkg

// file: rtl/ssr_word_if.sv
/*
  ssr_word_if: control and finished-word signals between the
  register side and the link shifter.
  assumes: both ends run on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface ssr_word_if;
  logic       shift_enable;
  logic       sample_rising;
  logic       nine_bit;
  logic       word_done;
  logic       busy;
  logic [8:0] word;

  modport shifter (input shift_enable, input sample_rising, input nine_bit,
                   output word_done, output busy, output word);
  modport ctrl    (output shift_enable, output sample_rising, output nine_bit,
                   input word_done, input busy, input word);
endinterface : ssr_word_if
`default_nettype wire

// file: rtl/ssr_shifter.sv
/*
  ssr_shifter: samples the external shift clock and data pins,
  shifts 8 or 9 bits lsb first and hands out each finished word.
  assumes: pins are asynchronous to core_clk and the link clock is
  at least four core_clk periods long.
*/
`timescale 1ns/1ps
`default_nettype none
module ssr_shifter (
  // clock and reset
  input  wire logic  core_clk,
  input  wire logic  arst_n,
  // link pins
  input  wire logic  link_clk_pin,
  input  wire logic  link_data_pin,
  // word side
  ssr_word_if.shifter wif
);

  logic [1:0] clk_sync_ff;
  logic [1:0] nxt_clk_sync;
  logic [1:0] data_sync_ff;
  logic [1:0] nxt_data_sync;
  logic       clk_prev_ff;
  logic       nxt_clk_prev;
  logic [3:0] count_ff;
  logic [3:0] nxt_count;
  logic [8:0] shreg_ff;
  logic [8:0] nxt_shreg;
  logic [8:0] word_ff;
  logic [8:0] nxt_word;
  logic       done_ff;
  logic       nxt_done;
  logic       sample_edge;
  logic [3:0] last_bit;

  // ------------------------------------------------------------
  // sampling and shifting
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_clk_sync  = {clk_sync_ff[0], link_clk_pin};
    nxt_data_sync = {data_sync_ff[0], link_data_pin};
    nxt_clk_prev  = clk_sync_ff[1];
    // edges only of the external clock move bits
    sample_edge   = wif.sample_rising ? (clk_sync_ff[1] & ~clk_prev_ff)
                                      : (~clk_sync_ff[1] & clk_prev_ff);
    last_bit      = wif.nine_bit ? ssr_pkg::LAST_BIT_9 : ssr_pkg::LAST_BIT_8;
    nxt_count     = count_ff;
    nxt_shreg     = shreg_ff;
    nxt_word      = word_ff;
    nxt_done      = 1'b0;
    if (!wif.shift_enable)
    begin
      // a half word is dropped, the next word starts clean
      nxt_count = ssr_pkg::COUNT_ZERO;
    end
    else if (sample_edge)
    begin
      nxt_shreg = {data_sync_ff[1], shreg_ff[8:1]};
      if (count_ff == last_bit)
      begin
        nxt_count = ssr_pkg::COUNT_ZERO;
        nxt_done  = 1'b1;
        nxt_word  = wif.nine_bit ? nxt_shreg : {1'b0, nxt_shreg[8:1]};
      end
      else
      begin
        nxt_count = count_ff + ssr_pkg::COUNT_ONE;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clk_sync_ff  <= 2'h0;
      data_sync_ff <= 2'h0;
      clk_prev_ff  <= 1'b0;
      count_ff     <= ssr_pkg::COUNT_ZERO;
      shreg_ff     <= 9'h000;
      word_ff      <= 9'h000;
      done_ff      <= 1'b0;
    end
    else
    begin
      clk_sync_ff  <= nxt_clk_sync;
      data_sync_ff <= nxt_data_sync;
      clk_prev_ff  <= nxt_clk_prev;
      count_ff     <= nxt_count;
      shreg_ff     <= nxt_shreg;
      word_ff      <= nxt_word;
      done_ff      <= nxt_done;
    end
  end

  assign wif.word_done = done_ff;
  assign wif.word      = word_ff;
  assign wif.busy      = (count_ff != ssr_pkg::COUNT_ZERO);

endmodule : ssr_shifter
`default_nettype wire

// file: rtl/ssr_irq.sv
/*
  ssr_irq: sticky event status, mask and one level interrupt.
  assumes: event pulses, read and write strobes come from core_clk logic.
*/
`timescale 1ns/1ps
`default_nettype none
module ssr_irq (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  // events and software access
  input  wire logic [ssr_pkg::EVT_W-1:0] evt_set,
  input  wire logic                      status_rd,
  input  wire logic                      mask_wr,
  input  wire logic [ssr_pkg::EVT_W-1:0] mask_wdata,
  // state
  output logic      [ssr_pkg::EVT_W-1:0] status,
  output logic      [ssr_pkg::EVT_W-1:0] mask,
  output logic                           irq
);

  logic [ssr_pkg::EVT_W-1:0] status_ff;
  logic [ssr_pkg::EVT_W-1:0] nxt_status;
  logic [ssr_pkg::EVT_W-1:0] mask_ff;
  logic [ssr_pkg::EVT_W-1:0] nxt_mask;
  logic                      irq_ff;
  logic                      nxt_irq;

  always_comb
  begin
    // an event landing on the clearing read survives it
    nxt_status = (status_rd ? '0 : status_ff) | evt_set;
    nxt_mask   = mask_wr ? mask_wdata : mask_ff;
    nxt_irq    = |(nxt_status & nxt_mask);
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_ff <= '0;
      mask_ff   <= '0;
      irq_ff    <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
      irq_ff    <= nxt_irq;
    end
  end

  assign status = status_ff;
  assign mask   = mask_ff;
  assign irq    = irq_ff;

endmodule : ssr_irq
`default_nettype wire

// file: sim/ssr_checker.sv
/*
  ssr_checker: port assertions for ssr_top, bound at the foot.
  assumes: one core_clk domain, arst_n async active low.
*/
`timescale 1ns/1ps
`default_nettype none
module ssr_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        arst_n,
  // avalon-mm slave
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // link and core
  input wire logic        link_clk_pin,
  input wire logic        link_data_pin,
  input wire logic        global_interrupt_enable,
  input wire logic        peripheral_interrupt_enable,
  input wire logic        rx_irq_req,
  input wire logic        wake_req,
  input wire logic        vector_req,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  logic take;
  logic mapped;
  assign take   = (avs_read || avs_write) && avs_waitrequest;
  assign mapped = (avs_address[1:0] == 2'h0) && (avs_address <= ssr_pkg::OFS_RX_INT);

  answer_one_a : assert property (take |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not low for exactly one cycle");
  upper_zero_a : assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  unmapped_zero_a : assert property (avs_read && avs_waitrequest && !mapped |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  rd_hold_a : assert property (!$past(take) |-> $stable(avs_readdata))
    else $error("read data changed without an access");
  wake_same_a : assert property (wake_req == rx_irq_req)
    else $error("wake request differs from receive request");
  vector_cause_a : assert property (vector_req |-> $past(global_interrupt_enable)
    && $past(peripheral_interrupt_enable) && (rx_irq_req || $past(rx_irq_req)))
    else $error("vector request without its enables");
  flag_clear_a : assert property (avs_read && avs_waitrequest && avs_address == ssr_pkg::OFS_RX_BUFFER
    |=> ##1 !rx_irq_req)
    else $error("buffer read did not clear receive request");
  flag_hold_a : assert property (rx_irq_req && !avs_read && !avs_write && !$past(avs_read || avs_write)
    |=> rx_irq_req)
    else $error("receive request dropped without software access");
  irq_fall_a : assert property ($fell(irq) |-> $past(avs_read || avs_write))
    else $error("interrupt fell without software access");
endmodule : ssr_checker

bind ssr_top ssr_checker u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_clk_pin(link_clk_pin),
  .link_data_pin(link_data_pin), .global_interrupt_enable(global_interrupt_enable),
  .peripheral_interrupt_enable(peripheral_interrupt_enable), .rx_irq_req(rx_irq_req),
  .wake_req(wake_req), .vector_req(vector_req), .irq(irq)
);
`default_nettype wire

// file: sim/ssr_link_master.sv
/*
  ssr_link_master: external synchronous master driving shift clock and data.
  assumes: called by the bench; 800 ns bit period, lsb first.
*/
`timescale 1ns/1ps
`default_nettype none
module ssr_link_master (
  // link pins
  output logic link_clk_pin,
  output logic link_data_pin
);
  initial
  begin
    link_clk_pin  = 1'b0;
    link_data_pin = 1'b1;
  end

  // clock parks low between frames; odd offset keeps phase unrelated to core_clk
  task automatic send(input logic [8:0] w, input int n);
    #37;
    for (int i = 0; i < n; i++)
    begin
      link_data_pin = w[i];
      #200 link_clk_pin = 1'b1;
      #400 link_clk_pin = 1'b0;
      #200;
    end
    // released data shows the inverse, never the last bit
    link_data_pin = ~link_data_pin;
  endtask : send
endmodule : ssr_link_master
`default_nettype wire

// file: sim/tb.sv
/*
  tb: self-checking bench for ssr_top with a link master model.
  assumes: core_clk 10 MHz, registers on avalon-mm, link bit period 800 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        core_clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  wire         link_clk_pin, link_data_pin;
  logic        glob_en, periph_en, rx_irq_req, wake_req, vector_req, irq;
  int          err_total, n_compared;
  logic [31:0] exp_q [$];
  logic [8:0]  w0;
  logic [7:0]  r;
  logic [5:0]  rw_ofs [3] = '{ssr_pkg::OFS_TX_STATUS, ssr_pkg::OFS_BAUD_HI, ssr_pkg::OFS_BAUD_LO};

  ssr_top dut (
    .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_clk_pin(link_clk_pin),
    .link_data_pin(link_data_pin), .global_interrupt_enable(glob_en),
    .peripheral_interrupt_enable(periph_en), .rx_irq_req(rx_irq_req), .wake_req(wake_req),
    .vector_req(vector_req), .irq(irq)
  );
  ssr_link_master lm (.link_clk_pin(link_clk_pin), .link_data_pin(link_data_pin));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic print_verdict;
    $display("counts: compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic give_up;
    err_total++;
    $display("wrong value at %0t: wait expired", $time);
    print_verdict();
  endtask : give_up

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: output bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge core_clk);
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_address    <= a;
    avs_writedata  <= {24'h00_0000, d};
    avs_byteenable <= be;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
      give_up();
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00, 4'h1);
  endtask : rd

  task automatic wait_req;
    int n;
    n = 0;
    while (rx_irq_req !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    if (rx_irq_req !== 1'b1)
      give_up();
  endtask : wait_req

  // monitor takes the oldest note whenever read data stand
  always @(posedge core_clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk_rd(avs_readdata, exp_q.pop_front());

  initial
  begin
    {arst_n, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {glob_en, periph_en, err_total, n_compared} = '0;
    void'($urandom(32'hf469));
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    wr(6'h24, 8'hFF);
    for (int a = 0; a <= 'h24; a += 4)
      rd(6'(a), (6'(a) == ssr_pkg::OFS_BAUD_CTRL) ? 32'h0000_0040 : 32'h0000_0000);
    rd(6'h02, 32'h0000_0000);
    $display("test reset values done");
    foreach (rw_ofs[k])
    begin
      r = 8'($urandom);
      wr(rw_ofs[k], r);
      bus(1'b1, rw_ofs[k], ~r, 4'h0);
      rd(rw_ofs[k], {24'h00_0000, r});
    end
    r = 8'($urandom);
    wr(ssr_pkg::OFS_RX_STATUS, r);
    rd(ssr_pkg::OFS_RX_STATUS, {24'h00_0000, r & 8'hF8});
    $display("test register access done");
    wr(ssr_pkg::OFS_RX_STATUS, 8'h00);
    wr(ssr_pkg::OFS_TX_STATUS, 8'h10);
    wr(ssr_pkg::OFS_EVT_MASK, 8'h07);
    wr(ssr_pkg::OFS_RX_INT, 8'h01);
    wr(ssr_pkg::OFS_RX_STATUS, 8'h90);
    for (int i = 0; i < 4; i++)
    begin
      glob_en   <= i[0];
      periph_en <= 1'b1;
      wr(ssr_pkg::OFS_BAUD_CTRL, {3'h0, i[1], 4'h0});
      w0 = 9'($urandom);
      lm.send(w0, 8);
      wait_req();
      @(posedge core_clk);
      chk_bit(wake_req, 1'b1);
      chk_bit(irq, 1'b1);
      chk_bit(vector_req, i[0]);
      rd(ssr_pkg::OFS_RX_STATUS, 32'h0000_0090);
      rd(ssr_pkg::OFS_EVT_STATUS, 32'h0000_0001);
      rd(ssr_pkg::OFS_RX_BUFFER, {24'h00_0000, w0[7:0]});
      rd(ssr_pkg::OFS_RX_INT, 32'h0000_0001);
      chk_bit(irq, 1'b0);
    end
    $display("test eight bit words done");
    wr(ssr_pkg::OFS_RX_STATUS, 8'hD0);
    for (int j = 0; j < 2; j++)
    begin
      w0 = {j[0], 8'($urandom)};
      lm.send(w0, 9);
      wait_req();
      rd(ssr_pkg::OFS_RX_STATUS, {31'h0000_0068, w0[8]});
      rd(ssr_pkg::OFS_EVT_STATUS, 32'h0000_0001);
      rd(ssr_pkg::OFS_RX_BUFFER, {24'h00_0000, w0[7:0]});
    end
    $display("test nine bit words done");
    wr(ssr_pkg::OFS_RX_STATUS, 8'h90);
    w0 = 9'($urandom);
    lm.send(w0, 8);
    wait_req();
    lm.send(~w0, 8);
    repeat (20) @(posedge core_clk);
    rd(ssr_pkg::OFS_RX_STATUS, 32'h0000_0092);
    rd(ssr_pkg::OFS_EVT_STATUS, 32'h0000_0003);
    rd(ssr_pkg::OFS_RX_BUFFER, {24'h00_0000, w0[7:0]});
    wr(ssr_pkg::OFS_RX_STATUS, 8'h80);
    rd(ssr_pkg::OFS_RX_STATUS, 32'h0000_0080);
    lm.send(w0, 8);
    repeat (20) @(posedge core_clk);
    chk_bit(rx_irq_req, 1'b0);
    $display("test overrun done");
    wr(ssr_pkg::OFS_RX_STATUS, 8'h90);
    lm.send(w0, 4);
    wr(ssr_pkg::OFS_RX_STATUS, 8'h10);
    rd(ssr_pkg::OFS_RX_STATUS, 32'h0000_0014);
    rd(ssr_pkg::OFS_EVT_STATUS, 32'h0000_0004);
    wr(ssr_pkg::OFS_RX_STATUS, 8'h80);
    rd(ssr_pkg::OFS_RX_STATUS, 32'h0000_0080);
    $display("test framing done");
    wr(ssr_pkg::OFS_EVT_MASK, 8'h00);
    wr(ssr_pkg::OFS_RX_INT, 8'h00);
    wr(ssr_pkg::OFS_RX_STATUS, 8'h90);
    lm.send(w0, 8);
    repeat (20) @(posedge core_clk);
    chk_bit(rx_irq_req, 1'b0);
    chk_bit(irq, 1'b0);
    rd(ssr_pkg::OFS_RX_INT, 32'h0000_0002);
    wr(ssr_pkg::OFS_EVT_MASK, 8'h01);
    repeat (2) @(posedge core_clk);
    chk_bit(irq, 1'b1);
    rd(ssr_pkg::OFS_EVT_STATUS, 32'h0000_0001);
    rd(ssr_pkg::OFS_RX_BUFFER, {24'h00_0000, w0[7:0]});
    rd(ssr_pkg::OFS_RX_INT, 32'h0000_0000);
    $display("test masked interrupt done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
